// file: design/dpbs_boot_select.sv
`timescale 1ns/1ps
module dpbs_boot_select
  import dpbs_pkg::*;
#(
  parameter int SEQ_W  = 12,  // width of one boot order value
  parameter int ADDR_W = 24   // flash instruction word address width
) (
  input  wire logic                 mclk,          // system clock, 100 MHz
  input  wire logic                 rst_n,         // async reset, active low
  input  wire logic                 dual_mode_pin, // strap: 1 = dual partition
  input  wire logic [2*SEQ_W-1:0]   cfg_word1,     // partition 1 {inverse, value}
  input  wire logic [2*SEQ_W-1:0]   cfg_word2,     // partition 2 {inverse, value}
  input  wire logic                 cfg_valid,     // config words present
  output logic                      cfg_rd_q,      // config fetch request pulse
  input  wire logic                 swap_exec,     // swap instruction executed
  input  wire logic [7:0]           reg_addr,      // register byte address
  input  wire logic [31:0]          reg_wdata,     // register write data
  input  wire logic                 reg_wr,        // write strobe
  input  wire logic                 reg_rd,        // read strobe
  output logic [31:0]               reg_rdata_q,   // read data, cycle after
  output logic                      active_p2_q,   // partition 2 active
  output logic                      boot_done_q,   // selection complete
  output logic                      op_start_q,    // flash operation pulse
  output logic                      op_erase_q,    // 1 erase, 0 write
  output logic [ADDR_W-1:0]         op_addr_q      // block aligned address
);

  // parameter sanity: the erase block must fit in the address
  if (SEQ_W < 1 || SEQ_W > 14 || ADDR_W < 10 || ADDR_W > 32) begin : g_chk
    $error("dpbs_boot_select: unsupported SEQ_W or ADDR_W");
  end

  localparam logic [ADDR_W-1:0] WR_MASK = ADDR_W'(WRITE_BLK_WORDS - 16'h0001);
  localparam logic [ADDR_W-1:0] ER_MASK = ADDR_W'(ERASE_BLK_WORDS - 16'h0001);

  logic [1:0]        rst_pipe_q;
  logic              rst_sync_n;
  logic              dual_meta_q;
  logic              dual_sync_q;
  logic              dual_q;
  dpbs_state_t       state_q;
  logic [SEQ_W-1:0]  seq1_q;
  logic [SEQ_W-1:0]  seq2_q;
  logic              bad1_q;
  logic              bad2_q;
  logic              reset_sel_q;
  logic              erase_q;
  logic [ADDR_W-1:0] addr_q;
  logic              bad1_d;
  logic              bad2_d;
  logic              sel_p2_d;
  logic [31:0]       rdata_d;
  logic              start_req;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_q[1];

  // strap pin crosses in through two flops; kept out of reset so the
  // synchronised level is already settled when cfg_valid is held high
  // and the words are taken at the first edge in the fetch window
  always_ff @(posedge mclk) begin
    dual_meta_q <= dual_mode_pin;
    dual_sync_q <= dual_meta_q;
  end

  // boot sequencer: one fetch and one evaluation per reset
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q  <= ST_LOAD;
      cfg_rd_q <= 1'b0;
    end else begin
      case (state_q)
        ST_LOAD: begin
          cfg_rd_q <= 1'b1;
          state_q  <= ST_WAIT;
        end
        ST_WAIT: begin
          cfg_rd_q <= 1'b0;
          if (cfg_valid) begin
            state_q <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          state_q <= ST_RUN;  // terminal until the next reset
        end
        default: begin
          state_q <= ST_LOAD;
        end
      endcase
    end
  end

  // a value is intact only when its stored inverse matches
  assign bad1_d = cfg_word1[2*SEQ_W-1:SEQ_W] != ~cfg_word1[SEQ_W-1:0];
  assign bad2_d = cfg_word2[2*SEQ_W-1:SEQ_W] != ~cfg_word2[SEQ_W-1:0];

  // capture words only in the fetch window, so later reprogramming waits
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seq1_q <= '0;
      seq2_q <= '0;
      bad1_q <= 1'b1;
      bad2_q <= 1'b1;
      dual_q <= 1'b0;
    end else if (state_q == ST_WAIT && cfg_valid) begin
      seq1_q <= cfg_word1[SEQ_W-1:0];
      seq2_q <= cfg_word2[SEQ_W-1:0];
      bad1_q <= bad1_d;
      bad2_q <= bad2_d;
      dual_q <= dual_sync_q;
    end
  end

  // selection; ties and double corruption fall to partition 1
  always_comb begin
    sel_p2_d = 1'b0;
    if (dual_q) begin  // single mode never looks at the words
      if (bad1_q && !bad2_q) begin
        sel_p2_d = 1'b1;
      end else if (!bad1_q && !bad2_q) begin
        sel_p2_d = seq2_q < seq1_q;
      end
    end
  end

  // reset-time choice is kept apart from the swapped run-time state
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reset_sel_q <= 1'b0;
      boot_done_q <= 1'b0;
    end else if (state_q == ST_EVAL) begin
      reset_sel_q <= sel_p2_d;
      boot_done_q <= 1'b1;
    end
  end

  // physical active partition; swap only means something in dual mode
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      active_p2_q <= 1'b0;
    end else if (state_q == ST_EVAL) begin
      active_p2_q <= sel_p2_d;
    end else if (state_q == ST_RUN && swap_exec && dual_q) begin
      active_p2_q <= ~active_p2_q;
    end
  end

  // register writes
  assign start_req = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START_BIT]
                     && state_q == ST_RUN;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      erase_q <= RST_WORD[0];
      addr_q  <= RST_WORD[ADDR_W-1:0];
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        erase_q <= reg_wdata[CTRL_ERASE_BIT];
      end
      if (reg_addr == REG_ADDR) begin
        addr_q <= reg_wdata[ADDR_W-1:0];
      end
    end
  end

  // operation launch; address forced to the block boundary of the kind
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      op_start_q <= 1'b0;
      op_erase_q <= 1'b0;
      op_addr_q  <= '0;
    end else begin
      op_start_q <= start_req;
      if (start_req) begin
        op_erase_q <= reg_wdata[CTRL_ERASE_BIT];
        op_addr_q  <= reg_wdata[CTRL_ERASE_BIT] ? (addr_q & ~ER_MASK)
                                                : (addr_q & ~WR_MASK);
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      REG_CTRL: begin
        rdata_d[CTRL_ERASE_BIT] = erase_q;
        rdata_d[CTRL_DUAL_BIT]  = dual_q;
        rdata_d[CTRL_DONE_BIT]  = boot_done_q;
        rdata_d[CTRL_P2_BIT]    = active_p2_q;
      end
      REG_ADDR: begin
        rdata_d[ADDR_W-1:0] = addr_q;
      end
      REG_GEOM: begin
        rdata_d = {ERASE_BLK_WORDS, WRITE_BLK_WORDS};
      end
      REG_BOOT: begin
        rdata_d[BOOT_BAD1_BIT] = bad1_q;
        rdata_d[BOOT_BAD2_BIT] = bad2_q;
        rdata_d[BOOT_SEL_BIT]  = reset_sel_q;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata_q <= RST_WORD;
    end else begin
      reg_rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  logic eval_dual;
  assign eval_dual = state_q == ST_EVAL && dual_q;

  sequence fetch_s;
    state_q == ST_WAIT && cfg_valid;
  endsequence
  sequence settle_s;
    state_q == ST_EVAL ##1 state_q == ST_RUN && boot_done_q;
  endsequence

  lower_wins_a: assert property (
    eval_dual && !bad1_q && !bad2_q && seq1_q != seq2_q
    |=> active_p2_q == (seq2_q < seq1_q))
    else $error("lower boot order value not selected");
  single_mode_a: assert property (
    state_q == ST_EVAL && !dual_q |=> !active_p2_q && !reset_sel_q)
    else $error("single mode selected partition 2");
  words_held_a: assert property (
    state_q == ST_RUN |=> $stable(seq1_q) && $stable(seq2_q) && $stable(reset_sel_q))
    else $error("boot order changed without reset");
  tie_fallback_a: assert property (
    eval_dual && ((bad1_q && bad2_q) || (!bad1_q && !bad2_q && seq1_q == seq2_q))
    |=> !active_p2_q)
    else $error("tie did not select partition 1");
  one_corrupt_a: assert property (
    eval_dual && (bad1_q ^ bad2_q) |=> active_p2_q == bad1_q)
    else $error("corrupted partition selected");
  swap_toggle_a: assert property (
    state_q == ST_RUN && swap_exec && dual_q |=> active_p2_q != $past(active_p2_q))
    else $error("swap did not exchange partitions");
  swap_reset_a: assert property (
    state_q == ST_RUN && swap_exec |=> $stable(reset_sel_q))
    else $error("swap altered reset selection");
  status_bit_a: assert property (
    reg_rd && reg_addr == REG_CTRL |=> reg_rdata_q[CTRL_P2_BIT] == $past(active_p2_q))
    else $error("status bit does not match active partition");
  block_align_a: assert property (
    op_start_q |-> (op_addr_q & (op_erase_q ? ER_MASK : WR_MASK)) == '0)
    else $error("flash operation not block aligned");
  boot_once_a: assert property (
    fetch_s |=> settle_s ##1 (!cfg_rd_q && state_q == ST_RUN)[*3])
    else $error("boot sequence not sampled once");
  // run-time behaviour after the boot choice is made, and idle read data in every state
  done_held_a: assert property (
    state_q == ST_RUN |-> boot_done_q)
    else $error("running without a boot selection");
  strap_kept_a: assert property (
    state_q == ST_RUN |=> $stable(dual_q))
    else $error("partition mode changed without reset");
  single_stay_a: assert property (
    state_q == ST_RUN && !dual_q |=> !active_p2_q)
    else $error("single mode left partition 1");
  read_idle_a: assert property (
    !reg_rd |=> reg_rdata_q == 32'h0000_0000)
    else $error("read data shown without a read");
  start_gate_a: assert property (
    op_start_q |-> $past(state_q) == ST_RUN)
    else $error("flash operation launched before boot");

endmodule : dpbs_boot_select

// file: design/dpbs_pkg.sv
package dpbs_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_GEOM = 8'h08;
  localparam logic [7:0] REG_BOOT = 8'h0c;
  // control register fields
  localparam int CTRL_ERASE_BIT = 0;
  localparam int CTRL_DUAL_BIT  = 1;
  localparam int CTRL_DONE_BIT  = 2;
  localparam int CTRL_P2_BIT    = 10;
  localparam int CTRL_START_BIT = 15;
  // boot status register fields
  localparam int BOOT_BAD1_BIT  = 0;
  localparam int BOOT_BAD2_BIT  = 1;
  localparam int BOOT_SEL_BIT   = 2;
  // flash block geometry, in instruction words
  localparam logic [15:0] WRITE_BLK_WORDS = 16'h0040;
  localparam logic [15:0] ERASE_BLK_WORDS = 16'h0200;
  localparam int GEOM_ERASE_LSB = 16;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {ST_LOAD, ST_WAIT, ST_EVAL, ST_RUN} dpbs_state_t;
endpackage : dpbs_pkg

// file: test/dpbs_cfg_model.sv
`timescale 1ns/1ps
// stand-in for the flash array answering the boot order fetch
module dpbs_cfg_model (
  input  wire logic        mclk,      // system clock
  input  wire logic        rst_n,     // async reset, active low
  input  wire logic        cfg_rd_q,  // fetch request pulse
  input  wire logic        slow,      // 1 = answer late
  input  wire logic [23:0] word1_i,   // stored partition 1 word
  input  wire logic [23:0] word2_i,   // stored partition 2 word
  output logic      [23:0] cfg_word1, // word to the block
  output logic      [23:0] cfg_word2, // word to the block
  output logic             cfg_valid  // words present
);
  logic [2:0] wait_q;
  // answer one or five cycles after the request, then hold valid
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q    <= 3'h0;
      cfg_valid <= 1'b0;
    end else if (cfg_rd_q) begin
      wait_q <= slow ? 3'h5 : 3'h1;
    end else if (wait_q != 3'h0) begin
      wait_q    <= wait_q - 3'h1;
      cfg_valid <= (wait_q == 3'h1);
    end
  end
  // undriven lines show the bitwise inverse, which passes the inverse check whenever the stored word does
  assign cfg_word1 = cfg_valid ? word1_i : ~word1_i;
  assign cfg_word2 = cfg_valid ? word2_i : ~word2_i;
endmodule : dpbs_cfg_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dpbs_pkg::*;
  logic mclk, rst_n, dual, slow, swap_exec, cfg_valid, cfg_rd_q, reg_wr, reg_rd;
  logic active_p2_q, boot_done_q, op_start_q, op_erase_q;
  logic [23:0] w1, w2, cfg_word1, cfg_word2, op_addr_q, a;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, rd, seed, rnd;
  int n_mismatch, total_checks;

  dpbs_boot_select u_dpbs_boot_select (.mclk(mclk), .rst_n(rst_n), .dual_mode_pin(dual),
    .cfg_word1(cfg_word1), .cfg_word2(cfg_word2), .cfg_valid(cfg_valid),
    .cfg_rd_q(cfg_rd_q), .swap_exec(swap_exec), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .active_p2_q(active_p2_q), .boot_done_q(boot_done_q), .op_start_q(op_start_q),
    .op_erase_q(op_erase_q), .op_addr_q(op_addr_q));
  dpbs_cfg_model u_dpbs_cfg_model (.mclk(mclk), .rst_n(rst_n), .cfg_rd_q(cfg_rd_q),
    .slow(slow), .word1_i(w1), .word2_i(w2), .cfg_word1(cfg_word1),
    .cfg_word2(cfg_word2), .cfg_valid(cfg_valid));

  // free running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : lfsr
  // intact word keeps the inverse in the upper half; bad flips one bit
  function automatic logic [23:0] mk(input logic [11:0] v, input logic bad);
    return {~v ^ {11'h000, bad}, v};
  endfunction : mk
  // selection expected from the boot order values
  function automatic logic exp_p2(input logic d, b1, b2, input logic [11:0] v1, v2);
    if (!d || (b1 && b2)) return 1'b0;
    if (b1 || b2) return b1;
    return v2 < v1;
  endfunction : exp_p2

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd_reg(input logic [7:0] ad);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata_q;
  endtask : rd_reg
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic swap();
    @(posedge mclk);
    swap_exec <= 1'b1;
    @(posedge mclk);
    swap_exec <= 1'b0;
    #1;
  endtask : swap
  // reset with given straps and words, then check the selection
  task automatic boot(input logic d, b1, b2, input logic [11:0] v1, v2);
    logic e;
    int i;
    e = exp_p2(d, b1, b2, v1, v2);
    @(posedge mclk);
    dual  <= d;
    w1    <= mk(v1, b1);
    w2    <= mk(v2, b2);
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    i = 0;
    while (boot_done_q !== 1'b1 && i < 40) begin
      @(posedge mclk);
      #1 i++;
    end
    chk(boot_done_q, 1);
    chk(active_p2_q, e);
    rd_reg(REG_CTRL);
    chk({rd[CTRL_P2_BIT], rd[CTRL_DUAL_BIT], rd[CTRL_DONE_BIT]}, {e, d, 1'b1});
    rd_reg(REG_BOOT);
    if (d) chk(rd[2:0], {e, b2, b1});
  endtask : boot

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // watchdog well beyond the expected run
  initial begin
    #300000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {rst_n, dual, slow, swap_exec, reg_wr, reg_rd} = '0;
    {w1, w2, reg_addr, reg_wdata} = '0;
    seed = 32'hd8dd5704;
    boot(1, 0, 0, 12'h005, 12'h005);
    boot(1, 1, 1, 12'h001, 12'h009);
    boot(1, 1, 0, 12'h001, 12'hfff);
    boot(1, 0, 1, 12'hfff, 12'h000);
    boot(1, 0, 0, 12'hfff, 12'h000);
    boot(0, 0, 0, 12'h009, 12'h003);
    boot(0, 1, 0, 12'h009, 12'h003);
    repeat (12) begin
      rnd = lfsr();
      slow <= rnd[31];
      rnd = lfsr();
      a = rnd[23:0];
      boot(1, a[0] & a[1], a[2] & a[3], a[11:0], a[23:12]);
    end
    // new words after boot must not move the selection
    boot(1, 0, 0, 12'h002, 12'h008);
    w2 <= mk(12'h001, 1'b0);
    repeat (10) @(posedge mclk);
    #1 chk(active_p2_q, 0);
    @(posedge mclk);
    swap_exec <= 1'b1;
    @(posedge mclk);
    #1 chk(active_p2_q, 1);
    @(posedge mclk);
    swap_exec <= 1'b0;
    #1 chk(active_p2_q, 0);
    swap();
    chk(active_p2_q, 1);
    boot(1, 0, 0, 12'h002, 12'h008);
    swap();
    chk(active_p2_q, 1);
    boot(0, 0, 0, 12'h002, 12'h001);
    swap();
    chk(active_p2_q, 0);
    // block geometry, address alignment and an unmapped place
    rd_reg(REG_GEOM);
    chk(rd, {ERASE_BLK_WORDS, WRITE_BLK_WORDS});
    rd_reg(8'h10);
    chk(rd, 0);
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr();
      a = rnd[23:0];
      wr_reg(REG_ADDR, {8'h00, a});
      wr_reg(8'h14, 32'hffff_ffff);
      rd_reg(REG_ADDR);
      chk(rd, {8'h00, a});
      wr_reg(REG_CTRL, 32'h8000 | k[0]);
      chk({op_start_q, op_erase_q}, {1'b1, k[0]});
      chk(op_addr_q, a & ~((k[0] ? ERASE_BLK_WORDS : WRITE_BLK_WORDS) - 1));
      @(posedge mclk);
      #1 chk(op_start_q, 0);
    end
    wrap_up();
  end
endmodule : testbench
